// >>> logic/odc_pkg.sv
// Purpose: shared constants for the opcode decode and control block
// Assumes: 12-bit instruction words, 8-bit data path
// Notes:   opcodes are given in hex; the octal groups map bit for bit
package odc_pkg;

    // data-bus source, selected by the low two opcode bits
    typedef enum logic [1:0] {
        DSRC_LIT = 2'b00,
        DSRC_MEM = 2'b01,
        DSRC_AUX = 2'b10,
        DSRC_ACC = 2'b11
    } odc_dsrc_type;

    // single-word opcodes
    localparam logic [11:0] OP_DSRC_BASE  = 12'h180;
    localparam logic [11:0] OP_AUX_OR     = 12'h184;
    localparam logic [11:0] OP_ADDR_HIGH  = 12'h186;
    localparam logic [11:0] OP_AUX_CLR    = 12'h187;
    localparam logic [11:0] OP_ACC_CLR    = 12'h188;
    localparam logic [11:0] OP_ACC_ALU    = 12'h189;
    localparam logic [11:0] OP_ACC_HIGH   = 12'h18a;
    localparam logic [11:0] OP_ACC_LOW    = 12'h18b;
    localparam logic [11:0] OP_STORE      = 12'h18c;
    localparam logic [11:0] OP_IOREG_ACC  = 12'h18d;
    localparam logic [11:0] OP_SER_START  = 12'h18f;
    localparam logic [11:0] OP_BUS_REL    = 12'h190;
    localparam logic [11:0] OP_IRQ_EN     = 12'h191;
    localparam logic [11:0] OP_ACK_HIGH   = 12'h192;
    localparam logic [11:0] OP_PAGE_ONE   = 12'h194;
    localparam logic [11:0] OP_SCLK_HIGH  = 12'h195;
    localparam logic [11:0] OP_LOAD_HIGH  = 12'h196;
    localparam logic [11:0] OP_DIR_WRITE  = 12'h197;
    localparam logic [11:0] OP_IO_RESET   = 12'h1b8;
    localparam logic [11:0] OP_ADDR_INC   = 12'h1ba;
    localparam logic [11:0] OP_BUS_CLAIM  = 12'h110;
    localparam logic [11:0] OP_IRQ_DIS    = 12'h111;
    localparam logic [11:0] OP_ACK_LOW    = 12'h112;
    localparam logic [11:0] OP_PAGE_ZERO  = 12'h114;
    localparam logic [11:0] OP_SCLK_LOW   = 12'h115;
    localparam logic [11:0] OP_LOAD_LOW   = 12'h116;
    localparam logic [11:0] OP_DIR_READ   = 12'h117;
    localparam logic [11:0] OP_ROT_ENABLE = 12'h380;
    localparam logic [11:0] OP_SHIFT_L    = 12'h30c;
    localparam logic [11:0] OP_ROTATE_L   = 12'h34c;

    // opcode groups: fixed upper bits of each range
    localparam logic [8:0] GRP_IOREG_IMM = 9'h033;
    localparam logic [6:0] GRP_CHANNEL   = 7'h0e;
    localparam logic [3:0] GRP_LITERAL   = 4'h2;
    localparam logic [1:0] GRP_ADDR_LOW  = 2'h1;
    localparam logic [5:0] GRP_ALU_MODE  = 6'h0c;
    localparam logic [6:0] GRP_JUMP_CLR  = 7'h00;
    localparam logic [6:0] GRP_JUMP_SET  = 7'h04;

    // branch flag numbers
    localparam logic [4:0] FLG_ACC_MSB = 5'h03;
    localparam logic [4:0] FLG_CARRY   = 5'h04;
    localparam logic [4:0] FLG_EQUAL   = 5'h05;
    localparam logic [4:0] FLG_DB0     = 5'h08;
    localparam logic [4:0] FLG_RELEASE = 5'h10;
    localparam int unsigned FLG_COUNT  = 24;

    // register map, byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_ADDR = 4'h8;
    localparam logic [3:0] REG_IO   = 4'hc;
    localparam logic       RUN_RST  = 1'b1;

endpackage : odc_pkg

// >>> logic/odc_alu.sv
// Purpose: shift and rotate paths of the ALU feeding the accumulator
// Assumes: other ALU functions live outside; default path passes data bus
// Notes:   carry is the bit shifted out of the accumulator
`timescale 1ns/1ps
`default_nettype none
module odc_alu #(
    parameter int unsigned DW = 8
) (
    // mode
    input  wire logic          shift_left,
    input  wire logic          rotate_left,
    // operands
    input  wire logic [DW-1:0] acc,
    input  wire logic [DW-1:0] dbus,
    // result
    output logic      [DW-1:0] f,
    output logic               carry
);
    always_comb begin
        f     = dbus;
        carry = 1'b0;
        if (shift_left) begin
            f     = {acc[DW-2:0], 1'b0};
            carry = acc[DW-1];
        end else if (rotate_left) begin
            f     = {acc[DW-2:0], acc[DW-1]};
            carry = acc[DW-1];
        end
    end
endmodule : odc_alu
`default_nettype wire

// >>> logic/odc_decode.sv
// Purpose: opcode decode and datapath control, one instruction per cycle
// Assumes: instruction memory presents a word with a valid strobe
// Notes:   Avalon-MM slave gives run control and state readback
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module odc_decode
    import odc_pkg::*;
#(
    parameter int unsigned DW    = 8,
    parameter int unsigned AW    = 12,
    parameter int unsigned DEPTH = 1024
) (
    // clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // instruction memory
    input  wire logic [11:0]          instr_word,
    input  wire logic                 instr_valid,
    // external branch flags, from pins
    input  wire logic [FLG_COUNT-1:0] ext_flags,
    // branch control
    output logic                      branch_taken,
    output logic                      branch_page,
    // I/O control
    output logic [2:0]                io_reg_num,
    output logic [4:0]                io_channel,
    output logic                      serial_clk,
    output logic                      serial_load,
    output logic                      serial_dir_write,
    output logic                      serial_start,
    output logic                      io_reset,
    output logic                      bus_release,
    output logic                      irq_enable,
    output logic                      irq_ack,
    // Avalon-MM slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest
);
    localparam int unsigned MW = $clog2(DEPTH);

    logic [DW-1:0]        acc_q, aux_q, lit_q;
    logic [AW-1:0]        addr_q;
    logic [DW-1:0]        mem [DEPTH];
    odc_dsrc_type         dsel_q;
    logic                 rot_en_q, shl_q, rol_q, run_q, ack_q;
    logic [FLG_COUNT-1:0] flg_s1_q, flg_s2_q, flags;
    logic [DW-1:0]        dbus, f;
    logic                 carry, exec, is_jump_set, is_jump_clr, flag_sel;
    logic [MW-1:0]        maddr;

    assign exec  = ce & run_q & instr_valid;
    assign maddr = addr_q[MW-1:0];

    // data bus mux
    always_comb begin
        case (dsel_q)
            DSRC_LIT: dbus = lit_q;
            DSRC_MEM: dbus = mem[maddr];
            DSRC_AUX: dbus = aux_q;
            DSRC_ACC: dbus = acc_q;
            default:  dbus = lit_q;
        endcase
    end

    odc_alu #(.DW(DW)) u_alu (
        .shift_left  (shl_q),
        .rotate_left (rol_q),
        .acc         (acc_q),
        .dbus        (dbus),
        .f           (f),
        .carry       (carry)
    );

    // external flags come from pins, so two stages first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flg_s1_q <= '0;
            flg_s2_q <= '0;
        end else if (ce) begin
            flg_s1_q <= ext_flags;
            flg_s2_q <= flg_s1_q;
        end
    end

    // internal flags override their external slots
    always_comb begin
        flags              = flg_s2_q;
        flags[0]           = 1'b0;
        flags[FLG_ACC_MSB] = acc_q[DW-1];
        flags[FLG_CARRY]   = carry;
        flags[FLG_EQUAL]   = (dbus == acc_q);
        flags[FLG_RELEASE] = bus_release;
        for (int i = 0; i < DW; i++) begin
            flags[FLG_DB0 + i] = dbus[i];
        end
    end

    assign is_jump_set = (instr_word[11:5] == GRP_JUMP_SET);
    assign is_jump_clr = (instr_word[11:5] == GRP_JUMP_CLR);
    assign flag_sel    = (instr_word[4:0] < 5'(FLG_COUNT))
                         ? flags[instr_word[4:0]] : 1'b0;

    // branch decision; code zero in each group is no-op / jump
    always_ff @(posedge core_clk) begin
        if (rst) begin
            branch_taken <= 1'b0;
        end else if (ce) begin
            branch_taken <= 1'b0;
            if (exec && is_jump_set) begin
                branch_taken <= (instr_word[4:0] == 5'h00) | flag_sel;
            end else if (exec && is_jump_clr && instr_word[4:0] != 5'h00) begin
                branch_taken <= ~flag_sel;
            end
        end
    end

    // page stays until changed, so it governs the next branch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            branch_page <= 1'b0;
        end else if (exec) begin
            if (instr_word == OP_PAGE_ZERO) branch_page <= 1'b0;
            if (instr_word == OP_PAGE_ONE)  branch_page <= 1'b1;
        end
    end

    // data-bus source and literal
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dsel_q <= DSRC_LIT;
            lit_q  <= '0;
        end else if (exec) begin
            if (instr_word[11:2] == OP_DSRC_BASE[11:2]) begin
                dsel_q <= odc_dsrc_type'(instr_word[1:0]);
            end
            if (instr_word[11:8] == GRP_LITERAL) begin
                lit_q <= instr_word[DW-1:0];
            end
        end
    end

    // accumulator and rotate enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_q    <= '0;
            rot_en_q <= 1'b0;
        end else if (exec) begin
            case (instr_word)
                OP_ACC_CLR:  acc_q <= '0;
                OP_ACC_ALU: begin
                    if (rot_en_q) begin
                        acc_q <= {acc_q[0], acc_q[DW-1:1]};
                    end else begin
                        acc_q <= f;
                    end
                end
                OP_ACC_HIGH: acc_q[DW-1:4] <= f[DW-1:4];
                OP_ACC_LOW:  acc_q[3:0]    <= f[3:0];
                OP_IOREG_ACC: acc_q <= acc_q;
                default:     acc_q <= acc_q;
            endcase
            // any ALU mode opcode cancels the rotate enable
            if (instr_word == OP_ROT_ENABLE) begin
                rot_en_q <= 1'b1;
            end else if (instr_word[11:6] == GRP_ALU_MODE ||
                         instr_word == OP_ROTATE_L) begin
                rot_en_q <= 1'b0;
            end
        end
    end

    // ALU shift and rotate mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shl_q <= 1'b0;
            rol_q <= 1'b0;
        end else if (exec) begin
            if (instr_word[11:6] == GRP_ALU_MODE ||
                instr_word == OP_ROTATE_L) begin
                shl_q <= (instr_word == OP_SHIFT_L);
                rol_q <= (instr_word == OP_ROTATE_L);
            end
        end
    end

    // auxiliary OR register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aux_q <= '0;
        end else if (exec) begin
            if (instr_word == OP_AUX_CLR) aux_q <= '0;
            if (instr_word == OP_AUX_OR)  aux_q <= aux_q | dbus;
        end
    end

    // RAM address register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_q <= '0;
        end else if (exec) begin
            if (instr_word == OP_ADDR_HIGH) begin
                addr_q[AW-1:AW-4] <= dbus[3:0];
            end else if (instr_word == OP_ADDR_INC) begin
                addr_q <= addr_q + AW'(1);
            end else if (instr_word[11:10] == GRP_ADDR_LOW) begin
                addr_q[9:0] <= instr_word[9:0];
            end
        end
    end

    // data memory; no reset, contents are software's
    always_ff @(posedge core_clk) begin
        if (exec && instr_word == OP_STORE) begin
            mem[maddr] <= dbus;
        end
    end

    // I/O register and channel numbers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_reg_num <= '0;
            io_channel <= '0;
        end else if (exec) begin
            if (instr_word == OP_IOREG_ACC) begin
                io_reg_num <= acc_q[2:0];
            end else if (instr_word[11:3] == GRP_IOREG_IMM) begin
                io_reg_num <= instr_word[2:0];
            end
            if (instr_word[11:5] == GRP_CHANNEL) begin
                io_channel <= instr_word[4:0];
            end
        end
    end

    // serial lines, bus release, interrupt enable and acknowledge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_clk       <= 1'b0;
            serial_load      <= 1'b0;
            serial_dir_write <= 1'b0;
            bus_release      <= 1'b0;
            irq_enable       <= 1'b0;
            irq_ack          <= 1'b0;
        end else if (exec) begin
            case (instr_word)
                OP_SCLK_LOW:  serial_clk       <= 1'b0;
                OP_SCLK_HIGH: serial_clk       <= 1'b1;
                OP_LOAD_LOW:  serial_load      <= 1'b0;
                OP_LOAD_HIGH: serial_load      <= 1'b1;
                OP_DIR_READ:  serial_dir_write <= 1'b0;
                OP_DIR_WRITE: serial_dir_write <= 1'b1;
                OP_BUS_REL:   bus_release      <= 1'b1;
                OP_BUS_CLAIM: bus_release      <= 1'b0;
                OP_IRQ_DIS:   irq_enable       <= 1'b0;
                OP_IRQ_EN:    irq_enable       <= 1'b1;
                OP_ACK_LOW:   irq_ack          <= 1'b0;
                OP_ACK_HIGH:  irq_ack          <= 1'b1;
                default:      irq_ack          <= irq_ack;
            endcase
        end
    end

    // one-cycle strobes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_start <= 1'b0;
            io_reset     <= 1'b0;
        end else if (ce) begin
            serial_start <= exec && instr_word == OP_SER_START;
            io_reset     <= exec && instr_word == OP_IO_RESET;
        end
    end

    // bus slave: one wait cycle, answer on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q        <= 1'b0;
            run_q        <= RUN_RST;
            avs_readdata <= '0;
        end else if (ce) begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            // write lands on the edge that completes the transfer
            if (avs_write && ack_q && avs_address == REG_CTRL) begin
                run_q <= avs_writedata[0];
            end
            if (avs_read && !ack_q) begin
                case (avs_address)
                    REG_CTRL: avs_readdata <= {30'h0, rot_en_q, run_q};
                    REG_DATA: avs_readdata <= {6'h0, dsel_q, lit_q,
                                               aux_q, acc_q};
                    REG_ADDR: avs_readdata <= {15'h0, branch_page,
                                               4'h0, addr_q};
                    REG_IO:   avs_readdata <= {10'h0, irq_ack, irq_enable,
                                               bus_release, serial_dir_write,
                                               serial_load, serial_clk, 3'h0,
                                               io_channel, 5'h0, io_reg_num};
                    default:  avs_readdata <= '0;
                endcase
            end
        end
    end

    // checks
    property p_acc_clear;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_ACC_CLR |=> acc_q == '0;
    endproperty
    a_acc_clear: assert property (p_acc_clear)
        else $error("accumulator not cleared");

    property p_aux_or;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_AUX_OR
        |=> aux_q == ($past(aux_q) | $past(dbus));
    endproperty
    a_aux_or: assert property (p_aux_or)
        else $error("aux OR result wrong");

    property p_addr_high;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_ADDR_HIGH
        |=> addr_q[AW-1:AW-4] == $past(dbus[3:0])
            && addr_q[AW-5:0] == $past(addr_q[AW-5:0]);
    endproperty
    a_addr_high: assert property (p_addr_high)
        else $error("address high nibble wrong");

    property p_store;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_STORE |=> mem[$past(maddr)] == $past(dbus);
    endproperty
    a_store: assert property (p_store)
        else $error("memory store wrong");

    property p_io_reg_imm;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word[11:3] == GRP_IOREG_IMM
        |=> io_reg_num == $past(instr_word[2:0]);
    endproperty
    a_io_reg_imm: assert property (p_io_reg_imm)
        else $error("io register number wrong");

    property p_channel;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word[11:5] == GRP_CHANNEL
        |=> io_channel == $past(instr_word[4:0]);
    endproperty
    a_channel: assert property (p_channel)
        else $error("io channel wrong");

    property p_serial_start;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_SER_START
        ##1 ce && !(exec && instr_word == OP_SER_START) |=> !serial_start;
    endproperty
    a_serial_start: assert property (p_serial_start)
        else $error("serial start longer than one cycle");

    property p_page_one;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_PAGE_ONE |=> branch_page;
    endproperty
    a_page_one: assert property (p_page_one)
        else $error("page one not selected");

    property p_jump_clr_carry;
        @(posedge core_clk) disable iff (rst)
        exec && is_jump_clr && instr_word[4:0] == FLG_CARRY
        |=> branch_taken == !$past(carry);
    endproperty
    a_jump_clr_carry: assert property (p_jump_clr_carry)
        else $error("carry clear branch wrong");

    property p_irq_ack;
        @(posedge core_clk) disable iff (rst)
        exec && instr_word == OP_ACK_HIGH |=> irq_ack && irq_enable
            == $past(irq_enable);
    endproperty
    a_irq_ack: assert property (p_irq_ack)
        else $error("acknowledge not raised");

endmodule : odc_decode
`default_nettype wire

// >>> bench/odc_imem_model.sv
// Purpose: instruction memory model, one word per fetch
// Assumes: caller issues fetches one at a time from a single process
// Notes:   between fetches the word lines hold the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module odc_imem_model (
    // clock
    input  wire logic  core_clk,
    // instruction port
    output var logic [11:0] instr_word,
    output var logic        instr_valid
);
    initial begin
        instr_word  = 12'h000;
        instr_valid = 1'b0;
    end
    // released lines invert, so a stale word never reads as valid data
    task issue(input logic [11:0] w);
        @(posedge core_clk);
        instr_word  <= w;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        instr_word  <= ~w;
    endtask : issue
endmodule : odc_imem_model
`default_nettype wire

// >>> bench/opcode_decode_control_tb.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: state is read back over the slave port
// Notes:   ALU modes other than shift and rotate pass the data bus
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_control_tb
    import odc_pkg::*;
;
    logic core_clk, rst, ce, instr_valid, avs_read, avs_write;
    logic [11:0] instr_word;
    logic [23:0] ext_flags;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic branch_taken, branch_page, serial_clk, serial_load;
    logic serial_dir_write, serial_start, io_reset, bus_release;
    logic irq_enable, irq_ack, avs_waitrequest;
    logic [2:0]  io_reg_num;
    logic [4:0]  io_channel;
    int          bad_count, samples_checked;
    wire logic [13:0] io_vec = {irq_ack, irq_enable, bus_release,
        serial_dir_write, serial_load, serial_clk, io_channel, io_reg_num};
    localparam logic [11:0] IO_OP [20] = '{12'h2f5, 12'h180, 12'h189,
        12'h18d, 12'h195, 12'h196, 12'h197, 12'h190, 12'h191, 12'h192,
        12'h1df, 12'h19f, 12'h198, 12'h1c0, 12'h115, 12'h116, 12'h117,
        12'h110, 12'h111, 12'h112};
    localparam logic [13:0] IO_EV [20] = '{14'h0000, 14'h0000, 14'h0000,
        14'h0005, 14'h0105, 14'h0305, 14'h0705, 14'h0f05, 14'h1f05,
        14'h3f05, 14'h3ffd, 14'h3fff, 14'h3ff8, 14'h3f00, 14'h3e00,
        14'h3c00, 14'h3800, 14'h3000, 14'h2000, 14'h0000};

    odc_imem_model odc_imem_model_i (.core_clk, .instr_word, .instr_valid);
    odc_decode odc_decode_i (.core_clk, .rst, .ce, .instr_word,
        .instr_valid, .ext_flags, .branch_taken, .branch_page, .io_reg_num,
        .io_channel, .serial_clk, .serial_load, .serial_dir_write,
        .serial_start, .io_reset, .bus_release, .irq_enable, .irq_ack,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task ex(input logic [11:0] w);
        odc_imem_model_i.issue(w);
    endtask : ex
    task acc_is(input string n, input logic [7:0] e);
        bus(1'b0, REG_DATA, 32'h0);
        chk(n, e, q[7:0]);
    endtask : acc_is
    task tk(input logic [11:0] op, input logic e);
        ex(op);
        @(negedge core_clk);
        chk("branch_taken", e, branch_taken);
    endtask : tk
    task t_regs;
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, q);
        bus(1'b0, REG_IO, 32'h0);
        chk("io reset", 32'h0, q);
        bus(1'b1, REG_CTRL, 32'h0);
        ex(OP_SCLK_HIGH);
        @(negedge core_clk);
        chk("halted sclk", 1'b0, serial_clk);
        bus(1'b1, REG_CTRL, 32'h1);
        @(posedge core_clk);
        ce <= 1'b0;
        ex(OP_SCLK_HIGH);
        @(negedge core_clk);
        chk("frozen sclk", 1'b0, serial_clk);
        @(posedge core_clk);
        ce <= 1'b1;
        bus(1'b1, 4'h2, 32'hffffffff);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test regs done");
    endtask : t_regs
    task t_dsrc;
        ex(12'h2ab);
        for (int i = 0; i < 4; i++) begin
            ex(OP_DSRC_BASE + 12'(i));
            bus(1'b0, REG_DATA, 32'h0);
            chk("dsrc", 32'(i), q[25:24]);
        end
        ex(OP_DSRC_BASE);
        $display("test dsrc done");
    endtask : t_dsrc
    task t_acc;
        ex(12'h25c);
        ex(OP_ACC_ALU);
        acc_is("acc alu", 8'h5c);
        ex(12'h2f3);
        ex(OP_ACC_HIGH);
        acc_is("acc high", 8'hfc);
        ex(12'h221);
        ex(OP_ACC_LOW);
        acc_is("acc low", 8'hf1);
        ex(OP_ACC_CLR);
        acc_is("acc clr", 8'h00);
        ex(12'h296);
        ex(OP_ACC_ALU);
        ex(OP_ROTATE_L);
        ex(OP_ACC_ALU);
        acc_is("rotl", 8'h2d);
        ex(OP_ROT_ENABLE);
        bus(1'b0, REG_CTRL, 32'h0);
        chk("rot en", 32'h3, q);
        ex(OP_ACC_ALU);
        acc_is("rotr", 8'h96);
        ex(OP_SHIFT_L);
        ex(OP_ACC_ALU);
        acc_is("shift", 8'h2c);
        ex(12'h300);
        $display("test acc done");
    endtask : t_acc
    task t_aux_mem;
        ex(12'h20f);
        ex(OP_AUX_OR);
        ex(12'h230);
        ex(OP_AUX_OR);
        bus(1'b0, REG_DATA, 32'h0);
        chk("aux or", 8'h3f, q[15:8]);
        ex(OP_AUX_CLR);
        bus(1'b0, REG_DATA, 32'h0);
        chk("aux clr", 8'h00, q[15:8]);
        ex(12'h405);
        ex(12'h20a);
        ex(OP_ADDR_HIGH);
        bus(1'b0, REG_ADDR, 32'h0);
        chk("addr", 12'ha05, q[11:0]);
        ex(12'h277);
        ex(OP_STORE);
        ex(12'h200);
        ex(OP_DSRC_BASE + 12'h1);
        ex(OP_ACC_ALU);
        acc_is("stored", 8'h77);
        ex(OP_DSRC_BASE);
        $display("test aux mem done");
    endtask : t_aux_mem
    task t_branch;
        ex(12'h277);
        tk(12'h085, 1'b1);
        @(negedge core_clk);
        chk("taken pulse", 1'b0, branch_taken);
        tk(12'h005, 1'b0);
        ex(12'h200);
        tk(12'h085, 1'b0);
        tk(12'h084, 1'b0);
        tk(12'h004, 1'b1);
        ex(OP_BUS_REL);
        tk(12'h090, 1'b1);
        ex(OP_BUS_CLAIM);
        tk(12'h090, 1'b0);
        @(posedge core_clk);
        ext_flags <= 24'h000002;
        repeat (3) @(posedge core_clk);
        tk(12'h081, 1'b1);
        @(posedge core_clk);
        ext_flags <= 24'h000000;
        ex(OP_PAGE_ONE);
        @(negedge core_clk);
        chk("page one", 1'b1, branch_page);
        ex(OP_PAGE_ZERO);
        @(negedge core_clk);
        chk("page zero", 1'b0, branch_page);
        $display("test branch done");
    endtask : t_branch
    task t_io;
        for (int i = 0; i < 20; i++) begin
            ex(IO_OP[i]);
            @(negedge core_clk);
            chk("ioreg", IO_EV[i][2:0], io_reg_num);
            chk("chan", IO_EV[i][7:3], io_channel);
            chk("serial", IO_EV[i][10:8], io_vec[10:8]);
            chk("bus rel", IO_EV[i][11], bus_release);
            chk("irq", IO_EV[i][13:12], io_vec[13:12]);
        end
        for (int j = 0; j < 2; j++) begin
            ex(j ? OP_IO_RESET : OP_SER_START);
            @(negedge core_clk);
            chk("pulse", j ? 2'b01 : 2'b10, {serial_start, io_reset});
            @(negedge core_clk);
            chk("pulse end", 2'b00, {serial_start, io_reset});
        end
        $display("test io done");
    endtask : t_io
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        #50000;
        bad_count++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        ext_flags = 24'h0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_dsrc();
        t_acc();
        t_aux_mem();
        t_branch();
        t_io();
        stop_test();
    end
endmodule : opcode_decode_control_tb
`default_nettype wire
